// >>> verilog/vco_cal_regs_map.svh
`ifndef VCO_CAL_REGS_MAP_SVH
`define VCO_CAL_REGS_MAP_SVH

// Serial frame layout: read flag, 15 address bits, 8 data bits, MSB first
`define FRAME_ADDR_W        15
`define FRAME_INSTR_LAST    5'h0F
`define FRAME_DATA_LAST     5'h07
`define FRAME_RW_BIT        15

// Register window of this bank
`define REG_COUNT           9
`define ADDR_CONV_TRIGGER   15'h0000
`define ADDR_SUPPLY_ALC_A   15'h002F
`define ADDR_STAGE_TIME     15'h0030
`define ADDR_TIMEOUT_LOW    15'h0031
`define ADDR_ADC_CONTROL    15'h0032
`define ADDR_SYNTH_LOCK     15'h0033
`define ADDR_SETTLE_WAIT    15'h0034
`define ADDR_ADC_CLK_DIV    15'h0035
`define ADDR_PUMP_TRIM      15'h0036
`define ADDR_TEST_BAND      15'h0037

// Register indices (address minus window base)
`define IDX_SUPPLY_ALC_A    4'h0
`define IDX_STAGE_TIME      4'h1
`define IDX_TIMEOUT_LOW     4'h2
`define IDX_ADC_CONTROL     4'h3
`define IDX_SYNTH_LOCK      4'h4
`define IDX_SETTLE_WAIT     4'h5
`define IDX_ADC_CLK_DIV     4'h6
`define IDX_PUMP_TRIM       4'h7
`define IDX_TEST_BAND       4'h8
`define IDX_MISS            4'hF

// Reset values
`define RST_SUPPLY_ALC_A    8'h92
`define RST_STAGE_TIME      8'h3F
`define RST_TIMEOUT_LOW     8'hA7
`define RST_ADC_CONTROL     8'h04
`define RST_SYNTH_LOCK      8'h0C
`define RST_SETTLE_WAIT     8'h9E
`define RST_ADC_CLK_DIV     8'h4C
`define RST_PUMP_TRIM       8'h30
`define RST_TEST_BAND       8'h00

// Writable bit masks; clear bits are reserved and read zero
`define MASK_SUPPLY_ALC_A   8'h9F
`define MASK_ADC_CONTROL    8'hBF
`define MASK_SYNTH_LOCK     8'h1F
`define MASK_FULL           8'hFF

// Field positions
`define BIT_REG_SUPPLY      7
`define BIT_RECT_BIAS       4
`define BIT_LOW_RANGE       3
`define BIT_ADC_MUX         7
`define BIT_ADC_CONVERT     3
`define BIT_ADC_ENABLE      2

// ADC clock period = divider * 4 + 2 clock cycles
`define ADC_DIV_ADD         10'h002

`endif

// >>> verilog/vco_cal_regs_pkg.sv
`default_nettype none

package vco_cal_regs_pkg;

  // Serial frame sequencer
  typedef enum logic [1:0] {
    FRAME_IDLE  = 2'b00,
    FRAME_INSTR = 2'b01,
    FRAME_DATA  = 2'b10,
    FRAME_DONE  = 2'b11
  } frame_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage

`default_nettype wire

// >>> verilog/pin_sync3.sv
`default_nettype none

module pin_sync3 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic resetLevel,
  input  wire logic pinIn,
  output logic      pinLevel
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // Three flops; the first is read only by the second
  always_ff @(posedge clk)
  begin
    stage1_r <= pinIn;
    stage2_r <= stage1_r;
    stage3_r <= stage2_r;
  end

  // A change is accepted once stages two and three agree, which masks one-cycle glitches.
  // Reset loads the pin's idle level so no false edge or select follows reset.
  always_ff @(posedge clk)
  begin
    if (rst)
      pinLevel <= resetLevel;
    else if (stage2_r == stage3_r)
      pinLevel <= stage3_r;
  end

endmodule

`default_nettype wire

// >>> verilog/adc_clk_divider.sv
`default_nettype none

`include "vco_cal_regs_map.svh"

module adc_clk_divider
  import vco_cal_regs_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire reg_byte_t divider,
  output logic           adcClkEn
);

  logic [9:0] period;
  logic [9:0] count_r;

  // Period in phase-detector cycles; the count restarts whenever the period shrinks below it
  assign period = {divider, 2'b00} + `ADC_DIV_ADD;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_r  <= 10'h000;
      adcClkEn <= 1'b0;
    end
    else if (count_r >= period - 10'h001)
    begin
      count_r  <= 10'h000;
      adcClkEn <= 1'b1;
    end
    else
    begin
      count_r  <= count_r + 10'h001;
      adcClkEn <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/vco_cal_alc_adc_config_regs.sv
// How it works
// - Bit 7 picks regulator supply, reset one.
// - Bit 4 sets core A rectifier bias.
// - Bit 3 picks core A low threshold range.
// - Nominal threshold resets to code 010.
// - Stage divider byte, reset 0x3F.
// - Ten-bit timeout split over two registers.
// - ADC input: temperature or tuning voltage.
// - Write to 0x00 starts conversion if bits 3 and 2 are set.
// - Five-bit synthetic lock wait, reset 0xC.
// - Five-bit settle wait; upper field resets to 0x4.
// - ADC clock is clk over div*4+2.
// - Band select applies only in test mode.
`default_nettype none

`include "vco_cal_regs_map.svh"

module vco_cal_alc_adc_config_regs
  import vco_cal_regs_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  // Three-wire serial control port
  input  wire logic  serClk,
  input  wire logic  serSelN,
  input  wire logic  serDataIn,
  output logic       serDataOut,
  output logic       serDataOe,
  // Oscillator test mode from elsewhere in the device
  input  wire logic  testModeEnable,
  // Configuration fields
  output logic       regulatorSupplyChoice,
  output logic       coreARectifierBias,
  output logic       coreALowThresholdRange,
  output logic [2:0] coreANominalThreshold,
  output logic [7:0] calStageDivider,
  output logic [9:0] calTimeout,
  output logic       adcInputSelect,
  output logic       adcEnable,
  output logic       adcQuickConvert,
  output logic       adcRepeatConvert,
  output logic       adcConvertStart,
  output logic       adcClkEn,
  output logic [4:0] synthLockWait,
  output logic [4:0] levelLoopSettleWait,
  output logic [2:0] calMachineTestField,
  output logic [7:0] pumpCurrentTrim,
  output logic       bandOverrideValid,
  output logic [7:0] testBandSelect
);

  // Map an address to a register index, or the miss code
  function automatic logic [3:0] regIndex(input logic [`FRAME_ADDR_W-1:0] addr);
    logic [`FRAME_ADDR_W-1:0] offs;
    offs = addr - `ADDR_SUPPLY_ALC_A;
    if (addr >= `ADDR_SUPPLY_ALC_A && addr <= `ADDR_TEST_BAND)
      regIndex = offs[3:0];
    else
      regIndex = `IDX_MISS;
  endfunction

  // Reset value per register index
  function automatic reg_byte_t resetValue(input logic [3:0] idx);
    unique case (idx)
      `IDX_SUPPLY_ALC_A: resetValue = `RST_SUPPLY_ALC_A;
      `IDX_STAGE_TIME:   resetValue = `RST_STAGE_TIME;
      `IDX_TIMEOUT_LOW:  resetValue = `RST_TIMEOUT_LOW;
      `IDX_ADC_CONTROL:  resetValue = `RST_ADC_CONTROL;
      `IDX_SYNTH_LOCK:   resetValue = `RST_SYNTH_LOCK;
      `IDX_SETTLE_WAIT:  resetValue = `RST_SETTLE_WAIT;
      `IDX_ADC_CLK_DIV:  resetValue = `RST_ADC_CLK_DIV;
      `IDX_PUMP_TRIM:    resetValue = `RST_PUMP_TRIM;
      `IDX_TEST_BAND:    resetValue = `RST_TEST_BAND;
      default:           resetValue = 8'h00;
    endcase
  endfunction

  // Writable bits per register index
  function automatic reg_byte_t writeMask(input logic [3:0] idx);
    unique case (idx)
      `IDX_SUPPLY_ALC_A: writeMask = `MASK_SUPPLY_ALC_A;
      `IDX_ADC_CONTROL:  writeMask = `MASK_ADC_CONTROL;
      `IDX_SYNTH_LOCK:   writeMask = `MASK_SYNTH_LOCK;
      default:           writeMask = `MASK_FULL;
    endcase
  endfunction

  // Pin synchronisers; the port clock must run well below clk/8
  logic sclkLevel;
  logic selNLevel;
  logic sdiLevel;

  pin_sync3 u_syncClk (
    .clk        (clk),
    .rst        (rst),
    .resetLevel (1'b0),
    .pinIn      (serClk),
    .pinLevel   (sclkLevel)
  );

  pin_sync3 u_syncSel (
    .clk        (clk),
    .rst        (rst),
    .resetLevel (1'b1),
    .pinIn      (serSelN),
    .pinLevel   (selNLevel)
  );

  pin_sync3 u_syncData (
    .clk        (clk),
    .rst        (rst),
    .resetLevel (1'b0),
    .pinIn      (serDataIn),
    .pinLevel   (sdiLevel)
  );

  // Rising edge of the filtered port clock, and select held low
  logic sclkPrev_r;
  logic sclkRise;
  logic selActive_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkPrev_r  <= 1'b0;
      selActive_r <= 1'b0;
    end
    else
    begin
      sclkPrev_r  <= sclkLevel;
      selActive_r <= ~selNLevel;
    end
  end

  assign sclkRise = sclkLevel & ~sclkPrev_r & selActive_r;

  // Frame sequencer
  frame_state_t               state_r;
  frame_state_t               state_nxt;
  logic [4:0]                 bitCnt_r;
  logic [15:0]                instr_r;
  logic [7:0]                 dataShift_r;
  logic [7:0]                 readShift_r;
  logic                       isRead_r;
  logic [`FRAME_ADDR_W-1:0]   addr_r;
  logic                       instrDone;
  logic                       dataDone;
  logic                       writeCommit;

  assign instrDone   = (state_r == FRAME_INSTR) && sclkRise && (bitCnt_r == `FRAME_INSTR_LAST);
  assign dataDone    = (state_r == FRAME_DATA) && sclkRise && (bitCnt_r == `FRAME_DATA_LAST);
  assign writeCommit = dataDone && !isRead_r;

  // Next state; a frame ends whenever select rises, even mid-byte
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      FRAME_IDLE:  if (selActive_r) state_nxt = FRAME_INSTR;
      FRAME_INSTR: if (instrDone) state_nxt = FRAME_DATA;
      FRAME_DATA:  if (dataDone) state_nxt = FRAME_DONE;
      FRAME_DONE:  state_nxt = FRAME_DONE;
    endcase
    if (!selActive_r)
      state_nxt = FRAME_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= FRAME_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bit counter restarts when select drops and when the instruction ends
  always_ff @(posedge clk)
  begin
    if (rst || !selActive_r || instrDone)
      bitCnt_r <= 5'h00;
    else if (sclkRise && (state_r == FRAME_INSTR || state_r == FRAME_DATA))
      bitCnt_r <= bitCnt_r + 5'h01;
  end

  // Instruction shift, MSB first; latch direction and address at its end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      instr_r  <= 16'h0000;
      isRead_r <= 1'b0;
      addr_r   <= 15'h0000;
    end
    else if (sclkRise && state_r == FRAME_INSTR)
    begin
      instr_r <= {instr_r[14:0], sdiLevel};
      if (instrDone)
      begin
        isRead_r <= instr_r[`FRAME_RW_BIT-1];
        addr_r   <= {instr_r[13:0], sdiLevel};
      end
    end
  end

  // Write data shift
  always_ff @(posedge clk)
  begin
    if (rst)
      dataShift_r <= 8'h00;
    else if (sclkRise && state_r == FRAME_DATA)
      dataShift_r <= {dataShift_r[6:0], sdiLevel};
  end

  logic [7:0] writeByte;
  logic [3:0] writeIdx;
  assign writeByte = {dataShift_r[6:0], sdiLevel};
  assign writeIdx  = regIndex(addr_r);

  // Register storage; only writable bits take new data, so reserved bits stay zero
  reg_byte_t regs_r [`REG_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++)
    begin : g_reg
      localparam logic [3:0] IDX = 4'(gi);
      always_ff @(posedge clk)
      begin
        if (rst)
          regs_r[gi] <= resetValue(IDX);
        else if (writeCommit && writeIdx == IDX)
          regs_r[gi] <= (regs_r[gi] & ~writeMask(IDX))
                        | (writeByte & writeMask(IDX));
      end
    end
  endgenerate

  // Read path: value captured as the instruction ends, shifted out after each rising edge
  logic [3:0] readIdx;
  assign readIdx = regIndex({instr_r[13:0], sdiLevel});

  always_ff @(posedge clk)
  begin
    if (rst)
      readShift_r <= 8'h00;
    else if (instrDone)
      readShift_r <= (readIdx == `IDX_MISS) ? 8'h00 : regs_r[readIdx];
    else if (sclkRise && state_r == FRAME_DATA)
      readShift_r <= {readShift_r[6:0], 1'b0};
  end

  assign serDataOut = readShift_r[7];
  assign serDataOe  = (state_r == FRAME_DATA) && isRead_r;

  // Conversion start; ADC control is sampled before this same frame could change it
  always_ff @(posedge clk)
  begin
    if (rst)
      adcConvertStart <= 1'b0;
    else
      adcConvertStart <= writeCommit && (addr_r == `ADDR_CONV_TRIGGER)
                         && regs_r[`IDX_ADC_CONTROL][`BIT_ADC_CONVERT]
                         && regs_r[`IDX_ADC_CONTROL][`BIT_ADC_ENABLE];
  end

  // Field outputs straight from register flops
  assign regulatorSupplyChoice  = regs_r[`IDX_SUPPLY_ALC_A][`BIT_REG_SUPPLY];
  assign coreARectifierBias     = regs_r[`IDX_SUPPLY_ALC_A][`BIT_RECT_BIAS];
  assign coreALowThresholdRange = regs_r[`IDX_SUPPLY_ALC_A][`BIT_LOW_RANGE];
  assign coreANominalThreshold  = regs_r[`IDX_SUPPLY_ALC_A][2:0];
  assign calStageDivider        = regs_r[`IDX_STAGE_TIME];
  assign calTimeout             = {regs_r[`IDX_ADC_CONTROL][1:0],
                                   regs_r[`IDX_TIMEOUT_LOW]};
  assign adcInputSelect         = regs_r[`IDX_ADC_CONTROL][`BIT_ADC_MUX];
  assign adcEnable              = regs_r[`IDX_ADC_CONTROL][`BIT_ADC_ENABLE];
  assign adcQuickConvert        = regs_r[`IDX_ADC_CONTROL][5];
  assign adcRepeatConvert       = regs_r[`IDX_ADC_CONTROL][4];
  assign synthLockWait          = regs_r[`IDX_SYNTH_LOCK][4:0];
  assign levelLoopSettleWait    = regs_r[`IDX_SETTLE_WAIT][4:0];
  assign calMachineTestField    = regs_r[`IDX_SETTLE_WAIT][7:5];
  assign pumpCurrentTrim        = regs_r[`IDX_PUMP_TRIM];

  // Band override is zero outside test mode so the calibrator keeps control
  assign bandOverrideValid = testModeEnable;
  assign testBandSelect    = testModeEnable ? regs_r[`IDX_TEST_BAND] : 8'h00;

  // ADC clock enable passes only while the ADC is enabled; the divider keeps counting regardless
  logic adcDivEn;

  adc_clk_divider u_adcDiv (
    .clk      (clk),
    .rst      (rst),
    .divider  (regs_r[`IDX_ADC_CLK_DIV]),
    .adcClkEn (adcDivEn)
  );

  assign adcClkEn = adcDivEn & adcEnable;

endmodule

`default_nettype wire

// >>> sim/vco_cal_regs_properties.sv
`default_nettype none

module vco_cal_regs_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       testModeEnable,
  input wire logic       regulatorSupplyChoice,
  input wire logic       coreARectifierBias,
  input wire logic       coreALowThresholdRange,
  input wire logic [2:0] coreANominalThreshold,
  input wire logic [7:0] calStageDivider,
  input wire logic [9:0] calTimeout,
  input wire logic       adcInputSelect,
  input wire logic       adcEnable,
  input wire logic       adcConvertStart,
  input wire logic       adcClkEn,
  input wire logic [4:0] synthLockWait,
  input wire logic [4:0] levelLoopSettleWait,
  input wire logic [2:0] calMachineTestField,
  input wire logic [7:0] testBandSelect
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Reset values are judged on the first cycle after release
  supply_rst_a: assert property ($fell(rst) |-> regulatorSupplyChoice && coreARectifierBias
    && !coreALowThresholdRange) else $error("supply bits wrong after reset");
  nominal_rst_a: assert property ($fell(rst) |-> coreANominalThreshold == 3'h2)
    else $error("nominal threshold wrong after reset");
  stage_rst_a: assert property ($fell(rst) |-> calStageDivider == 8'h3F)
    else $error("stage divider wrong after reset");
  timeout_rst_a: assert property ($fell(rst) |-> calTimeout == 10'h0A7)
    else $error("timeout wrong after reset");
  adc_rst_a: assert property ($fell(rst) |-> adcEnable && !adcInputSelect)
    else $error("adc control wrong after reset");
  wait_rst_a: assert property ($fell(rst) |-> synthLockWait == 5'h0C
    && levelLoopSettleWait == 5'h1E && calMachineTestField == 3'h4)
    else $error("wait fields wrong after reset");
  // Conversion needs the enable and lasts one cycle only
  conv_pulse_a: assert property (adcConvertStart |-> adcEnable ##1 !adcConvertStart)
    else $error("conversion start malformed");
  // Divide ratio is at least two, so strobes never touch
  clk_strobe_a: assert property (adcClkEn |-> (adcEnable || $past(adcEnable)) ##1 !adcClkEn)
    else $error("adc clock strobe malformed");
  // A registered gate may lag the mode by one cycle
  band_gate_a: assert property (testBandSelect != 8'h00 |-> testModeEnable || $past(testModeEnable))
    else $error("band select leaks outside test mode");
endmodule

bind vco_cal_alc_adc_config_regs vco_cal_regs_properties u_vco_cal_regs_properties (
  .clk, .rst, .testModeEnable, .regulatorSupplyChoice, .coreARectifierBias,
  .coreALowThresholdRange, .coreANominalThreshold, .calStageDivider, .calTimeout,
  .adcInputSelect, .adcEnable, .adcConvertStart, .adcClkEn, .synthLockWait,
  .levelLoopSettleWait, .calMachineTestField, .testBandSelect
);

`default_nettype wire

// >>> sim/vco_cal_alc_adc_config_regs_tb.sv
`default_nettype none

module vco_cal_alc_adc_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 0, rst = 1, serClk = 0, serSelN = 1, tbData = 0, testModeEnable = 0;
  wire        serDataIn;
  logic       serDataOut, serDataOe, regulatorSupplyChoice, coreARectifierBias;
  logic       coreALowThresholdRange, adcInputSelect, adcEnable, adcQuickConvert;
  logic       adcRepeatConvert, adcConvertStart, adcClkEn, bandOverrideValid;
  logic [2:0] coreANominalThreshold, calMachineTestField;
  logic [4:0] synthLockWait, levelLoopSettleWait;
  logic [7:0] calStageDivider, pumpCurrentTrim, testBandSelect, v;
  logic [9:0] calTimeout;
  int         err_count = 0, total_checks = 0, convCount = 0, n;
  logic [7:0] rstv[9] = '{8'h92, 8'h3F, 8'hA7, 8'h04, 8'h0C, 8'h9E, 8'h4C, 8'h30, 8'h00};
  logic [7:0] msk[9] = '{8'h9F, 8'hFF, 8'hFF, 8'hBF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] pat[9] = '{8'h08, 8'hC4, 8'h5A, 8'h83, 8'hF3, 8'h6B, 8'h03, 8'hA5, 8'hA5};

  vco_cal_alc_adc_config_regs u_vco_cal_alc_adc_config_regs (
    .clk                    (clk),
    .rst                    (rst),
    .serClk                 (serClk),
    .serSelN                (serSelN),
    .serDataIn              (serDataIn),
    .serDataOut             (serDataOut),
    .serDataOe              (serDataOe),
    .testModeEnable         (testModeEnable),
    .regulatorSupplyChoice  (regulatorSupplyChoice),
    .coreARectifierBias     (coreARectifierBias),
    .coreALowThresholdRange (coreALowThresholdRange),
    .coreANominalThreshold  (coreANominalThreshold),
    .calStageDivider        (calStageDivider),
    .calTimeout             (calTimeout),
    .adcInputSelect         (adcInputSelect),
    .adcEnable              (adcEnable),
    .adcQuickConvert        (adcQuickConvert),
    .adcRepeatConvert       (adcRepeatConvert),
    .adcConvertStart        (adcConvertStart),
    .adcClkEn               (adcClkEn),
    .synthLockWait          (synthLockWait),
    .levelLoopSettleWait    (levelLoopSettleWait),
    .calMachineTestField    (calMachineTestField),
    .pumpCurrentTrim        (pumpCurrentTrim),
    .bandOverrideValid      (bandOverrideValid),
    .testBandSelect         (testBandSelect)
  );

  // Clock and shared data pin: the block wins while its enable is up
  always #4 clk = ~clk;
  assign serDataIn = serDataOe ? serDataOut : tbData;
  always @(posedge clk) if (adcConvertStart === 1'b1) convCount++;

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One frame; phases of eight cycles clear the synchroniser with margin
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] f;
    f = {rd, a, wd};
    serSelN <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      tbData <= f[i];
      tick(8);
      if (i < 8) v[i] = serDataOut;
      serClk <= 1'b1;
      tick(8);
      serClk <= 1'b0;
    end
    tick(8);
    serSelN <= 1'b1;
    tbData <= ~tbData;
    tick(8);
  endtask

  task automatic rchk(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    check("read back", {2'b00, v}, {2'b00, e});
  endtask

  // Skips two strobes so a divider change has settled, then times the next gap
  task automatic period(input logic [9:0] e);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do begin @(negedge clk); n++; end while (adcClkEn !== 1'b1 && n < 2000);
    end
    check("adc clock period", n[9:0], e);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the fifty-seven frames of the sequence
  initial
  begin
    tick(80000);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    tick(16);
    rst <= 1'b0;
    tick(8);
    check("data pin idle", {9'h000, serDataOe}, 10'h000);
    check("supply fields", {regulatorSupplyChoice, coreARectifierBias, coreALowThresholdRange, coreANominalThreshold}, 10'h032);
    check("timeout", calTimeout, 10'h0A7);
    check("adc control", {adcInputSelect, adcEnable}, 10'h001);
    for (int i = 0; i < 9; i++) rchk(15'h002F + i, rstv[i]);
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 9; i++)
      begin
        xfer(1'b0, 15'h002F + i, k ? pat[i] : 8'hFF);
        rchk(15'h002F + i, (k ? pat[i] : 8'hFF) & msk[i]);
      end
    check("supply fields", {regulatorSupplyChoice, coreARectifierBias, coreALowThresholdRange, coreANominalThreshold}, 10'h008);
    check("stage divider", {2'b00, calStageDivider}, 10'h0C4);
    check("timeout", calTimeout, 10'h35A);
    check("adc control", {adcInputSelect, adcEnable}, 10'h002);
    check("lock wait", {5'h00, synthLockWait}, 10'h013);
    check("settle wait", {calMachineTestField, levelLoopSettleWait}, 10'h06B);
    check("band outside test", {bandOverrideValid, 1'b0, testBandSelect}, 10'h000);
    check("pump trim", {2'b00, pumpCurrentTrim}, 10'h0A5);
    check("convert modes", {8'h00, adcQuickConvert, adcRepeatConvert}, 10'h000);
    n = 0;
    repeat (400) @(negedge clk) if (adcClkEn !== 1'b0) n++;
    check("adc clock gated", n[9:0], 10'h000);
    testModeEnable <= 1'b1;
    tick(2);
    check("band in test", {bandOverrideValid, 1'b0, testBandSelect}, 10'h2A5);
    xfer(1'b0, 15'h0038, 8'h55);
    rchk(15'h0038, 8'h00);
    rchk(15'h002E, 8'h00);
    xfer(1'b0, 15'h0032, 8'h34);
    check("convert modes", {7'h00, adcQuickConvert, adcRepeatConvert, adcEnable}, 10'h007);
    for (int k = 0; k < 3; k++)
    begin
      xfer(1'b0, 15'h0032, k == 0 ? 8'h0C : (k == 1 ? 8'h04 : 8'h08));
      convCount = 0;
      xfer(1'b0, 15'h0000, 8'h00);
      check("conversions", convCount[9:0], k == 0 ? 10'h001 : 10'h000);
    end
    xfer(1'b0, 15'h0032, 8'h04);
    period(10'h00E);
    xfer(1'b0, 15'h0035, 8'h4C);
    period(10'h132);
    end_sim();
  end
endmodule

`default_nettype wire
